// ### hdl/iem_pkg.sv
// Contract
// - bit 15 gates link-change event onto interrupt
// - bit 14 gates frame-transmitted event
// - bit 13 gates frame-received event
// - bit 12 reads OR of time-stamp units whose enable and status are both set
// - bit 10 reads OR of trigger units whose enable and status are both set
// - bit 11 gates receive-overrun event
// - bit 9 gates transmit-stopped event
// - bit 8 gates receive-stopped event
// - bit 6 gates transmit-space-available event
// - bit 5 gates wake-frame event
// - bit 4 gates magic-packet event
// - bit 3 gates link-up wake event
// - bit 2 gates energy-detect wake event
// - interrupt asserts when status and enable coincide
// - status reads never clear; write one clears bits 15:8 and 6, the power-management clear code bits 5:2
package iem_pkg;

  // register offsets on the host bus (byte addresses)
  localparam logic [11:0] IEM_ENABLE_OFS = 12'h190;
  localparam logic [11:0] IEM_STATUS_OFS = 12'h192;

  // bit positions shared by the enable and the status register
  localparam int IEM_LINK_BIT = 15;
  localparam int IEM_TXDONE_BIT = 14;
  localparam int IEM_RXFRAME_BIT = 13;
  localparam int IEM_TSTAMP_BIT = 12;
  localparam int IEM_RXOVR_BIT = 11;
  localparam int IEM_TRIG_BIT = 10;
  localparam int IEM_TXSTOP_BIT = 9;
  localparam int IEM_RXSTOP_BIT = 8;
  localparam int IEM_SPARE_BIT = 7;
  localparam int IEM_TXSPACE_BIT = 6;
  localparam int IEM_WFRAME_BIT = 5;
  localparam int IEM_MAGIC_BIT = 4;
  localparam int IEM_LINKUP_BIT = 3;
  localparam int IEM_ENERGY_BIT = 2;

  // reset values
  localparam logic [15:0] IEM_ENABLE_RST = 16'h0000;
  localparam logic [15:0] IEM_STATUS_RST = 16'h0000;

  // bits that software may store in the enable register
  localparam logic [15:0] IEM_ENABLE_WMASK = 16'hEBFC;
  // status bits cleared by writing one
  localparam logic [15:0] IEM_W1C_MASK = 16'hFF40;
  // status bits cleared only through the power-management clear code
  localparam logic [15:0] IEM_PM_MASK = 16'h003C;
  // every status bit that exists at all
  localparam logic [15:0] IEM_STATUS_MASK = 16'hFF7C;

  // number of time-stamp input and trigger output units
  localparam int IEM_UNITS = 12;

  // byte-lane merge of a host write into an old register value
  function automatic logic [15:0] iem_merge(
    input logic [15:0] old_v,
    input logic [15:0] wr_v,
    input logic [1:0] be,
    input logic [15:0] mask
  );
    logic [15:0] lane;
    lane = {{8{be[1]}}, {8{be[0]}}} & mask;
    return (old_v & ~lane) | (wr_v & lane);
  endfunction

  // byte-lane qualified set of ones written by the host
  function automatic logic [15:0] iem_ones(
    input logic [15:0] wr_v,
    input logic [1:0] be,
    input logic [15:0] mask
  );
    return wr_v & {{8{be[1]}}, {8{be[0]}}} & mask;
  endfunction

endpackage

// ### hdl/iem_status.sv
`timescale 1ns/1ps
`default_nettype none
// sticky status bits; a set in the same cycle as a clear wins
module iem_status (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [15:0] set_pulse,
  input wire logic [15:0] clr_pulse,
  output logic [15:0] status_r
);
  import iem_pkg::*;

  logic [15:0] status_nxt; // next sticky value

  // clear first, then set, so an arriving event is never lost
  always_comb begin
    status_nxt = ((status_r & ~clr_pulse) | set_pulse) & IEM_STATUS_MASK;
  end

  // status holds across reads; only explicit clears drop bits
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      status_r <= IEM_STATUS_RST;
    end else begin
      status_r <= status_nxt;
    end
  end

endmodule
`default_nettype wire

// ### hdl/iem_top.sv
`timescale 1ns/1ps
`default_nettype none
// interrupt enable register, status register and host interrupt pin
module iem_top #(
  parameter int UNITS = iem_pkg::IEM_UNITS
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic host_cs,
  input wire logic host_wr,
  input wire logic host_rd,
  input wire logic [11:0] host_addr,
  input wire logic [1:0] host_be,
  input wire logic [15:0] host_wdata,
  output logic [15:0] host_rdata_r,
  input wire logic evt_link_change,
  input wire logic evt_tx_done,
  input wire logic evt_rx_frame,
  input wire logic evt_timestamp,
  input wire logic evt_rx_overrun,
  input wire logic evt_trigger,
  input wire logic evt_tx_stopped,
  input wire logic evt_rx_stopped,
  input wire logic evt_tx_space,
  input wire logic evt_wake_frame,
  input wire logic evt_magic_packet,
  input wire logic evt_linkup_wake,
  input wire logic evt_energy_wake,
  input wire logic [3:0] pm_clear,
  input wire logic [UNITS-1:0] timestamp_unit_enables,
  input wire logic [UNITS-1:0] timestamp_unit_status,
  input wire logic [UNITS-1:0] trigger_unit_enables,
  input wire logic [UNITS-1:0] trigger_unit_status,
  output logic irq_b_r
);
  import iem_pkg::*;

  logic [15:0] interrupt_enable_reg_r; // stored enable bits
  logic [15:0] interrupt_status_reg; // sticky status from the leaf
  logic [15:0] set_vec; // events gathered at their bit positions
  logic [15:0] clr_vec; // clears from host and power management
  logic [15:0] enable_view; // enable register as software reads it
  logic ts_summary; // any live time-stamp unit
  logic trig_summary; // any live trigger unit
  logic wr_enable; // host write hits the enable register
  logic wr_status; // host write hits the status register
  logic rd_hit_en; // host read of the enable register
  logic rd_hit_st; // host read of the status register

  // address decode; only the two words of this block answer
  always_comb begin
    wr_enable = host_cs && host_wr && (host_addr == IEM_ENABLE_OFS);
    wr_status = host_cs && host_wr && (host_addr == IEM_STATUS_OFS);
    rd_hit_en = host_cs && host_rd && (host_addr == IEM_ENABLE_OFS);
    rd_hit_st = host_cs && host_rd && (host_addr == IEM_STATUS_OFS);
  end

  // unit summaries: a unit counts while both its enable and its
  // status are set, so clearing either one drops the summary
  always_comb begin
    ts_summary = |(timestamp_unit_enables & timestamp_unit_status);
    trig_summary = |(trigger_unit_enables & trigger_unit_status);
  end

  // summaries replace the stored copy; bits 1:0 are hardwired zero
  always_comb begin
    enable_view = interrupt_enable_reg_r & IEM_ENABLE_WMASK;
    enable_view[IEM_TSTAMP_BIT] = ts_summary;
    enable_view[IEM_TRIG_BIT] = trig_summary;
  end

  // enable register; the write mask drops bits 12, 10, 1 and 0 so a
  // careless write there cannot disturb the read-only summaries
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      interrupt_enable_reg_r <= IEM_ENABLE_RST;
    end else if (wr_enable) begin
      interrupt_enable_reg_r <= iem_merge(interrupt_enable_reg_r,
        host_wdata, host_be, IEM_ENABLE_WMASK);
    end
  end

  // gather the single-cycle events at their status positions
  always_comb begin
    set_vec = 16'h0000;
    set_vec[IEM_LINK_BIT] = evt_link_change;
    set_vec[IEM_TXDONE_BIT] = evt_tx_done;
    set_vec[IEM_RXFRAME_BIT] = evt_rx_frame;
    set_vec[IEM_TSTAMP_BIT] = evt_timestamp;
    set_vec[IEM_RXOVR_BIT] = evt_rx_overrun;
    set_vec[IEM_TRIG_BIT] = evt_trigger;
    set_vec[IEM_TXSTOP_BIT] = evt_tx_stopped;
    set_vec[IEM_RXSTOP_BIT] = evt_rx_stopped;
    set_vec[IEM_TXSPACE_BIT] = evt_tx_space;
    set_vec[IEM_WFRAME_BIT] = evt_wake_frame;
    set_vec[IEM_MAGIC_BIT] = evt_magic_packet;
    set_vec[IEM_LINKUP_BIT] = evt_linkup_wake;
    set_vec[IEM_ENERGY_BIT] = evt_energy_wake;
  end

  // clears: write-one on edge bits, the one-hot code on wake bits;
  // a read never appears here, so reading cannot lose an event
  always_comb begin
    clr_vec = 16'h0000;
    if (wr_status) begin
      clr_vec = iem_ones(host_wdata, host_be, IEM_W1C_MASK);
    end
    clr_vec[IEM_WFRAME_BIT] = (pm_clear == 4'h8);
    clr_vec[IEM_MAGIC_BIT] = (pm_clear == 4'h4);
    clr_vec[IEM_LINKUP_BIT] = (pm_clear == 4'h2);
    clr_vec[IEM_ENERGY_BIT] = (pm_clear == 4'h1);
  end

  // sticky status bits live in the leaf module
  iem_status u_status (
    .clk(clk),
    .rst_b(rst_b),
    .set_pulse(set_vec),
    .clr_pulse(clr_vec),
    .status_r(interrupt_status_reg)
  );

  // interrupt pin, active low; bit 7 stores but never gates, because
  // its status partner does not exist and is masked off
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_b_r <= 1'b1;
    end else begin
      irq_b_r <= ~|(interrupt_status_reg & enable_view
        & IEM_STATUS_MASK);
    end
  end

  // read data registered; unmapped addresses read zero
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      host_rdata_r <= 16'h0000;
    end else if (rd_hit_en) begin
      host_rdata_r <= enable_view;
    end else if (rd_hit_st) begin
      host_rdata_r <= interrupt_status_reg;
    end else if (host_cs && host_rd) begin
      host_rdata_r <= 16'h0000;
    end
  end

  // ---- checks on the logic above ----
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  // a host write to the enable register on the given lane
  sequence hi_write_s;
    wr_enable && host_be[1];
  endsequence

  sequence lo_write_s;
    wr_enable && host_be[0];
  endsequence

  // a write that tries to clear the link-change status bit
  sequence link_clear_s;
    wr_status && host_be[1] && host_wdata[IEM_LINK_BIT];
  endsequence

  link_en_wr_a: assert property (
    hi_write_s |=> interrupt_enable_reg_r[IEM_LINK_BIT]
      == $past(host_wdata[IEM_LINK_BIT]))
    else $error("link enable did not take the written value");

  hi_en_wr_a: assert property (
    hi_write_s |=> interrupt_enable_reg_r[15:8]
      == $past(host_wdata[15:8] & IEM_ENABLE_WMASK[15:8]))
    else $error("upper enable byte did not take the written value");

  lo_en_wr_a: assert property (
    lo_write_s |=> interrupt_enable_reg_r[7:2] == $past(host_wdata[7:2]))
    else $error("lower enable byte did not take the written value");

  ts_sum_rd_a: assert property (
    rd_hit_en |=> host_rdata_r[IEM_TSTAMP_BIT]
      == $past(|(timestamp_unit_enables & timestamp_unit_status)))
    else $error("time-stamp summary read back wrong");

  trig_sum_rd_a: assert property (
    rd_hit_en |=> host_rdata_r[IEM_TRIG_BIT]
      == $past(|(trigger_unit_enables & trigger_unit_status)))
    else $error("trigger summary read back wrong");

  irq_gate_a: assert property (
    irq_b_r == !$past(|(interrupt_status_reg & enable_view)))
    else $error("interrupt pin disagrees with status and enable");

  rx_irq_path_a: assert property (
    (evt_rx_frame && enable_view[IEM_RXFRAME_BIT]
      && !wr_enable && !wr_status) |=> ##1 !irq_b_r)
    else $error("enabled frame-received event did not raise interrupt");

  read_no_clr_a: assert property (
    (host_rd && !wr_status && pm_clear == 4'h0)
      |=> (($past(interrupt_status_reg) & ~interrupt_status_reg) == 16'h0))
    else $error("status bit dropped without a clear");

  w1c_clear_a: assert property (
    (link_clear_s and !evt_link_change) |=> !interrupt_status_reg[IEM_LINK_BIT])
    else $error("write one did not clear link-change status");

  set_wins_a: assert property (
    (link_clear_s and evt_link_change) |=> interrupt_status_reg[IEM_LINK_BIT])
    else $error("event lost under a simultaneous clear");

  reserved_rd_a: assert property (
    rd_hit_en |=> host_rdata_r[1:0] == 2'h0
      && host_rdata_r[IEM_SPARE_BIT]
        == $past(interrupt_enable_reg_r[IEM_SPARE_BIT]))
    else $error("reserved enable bits read back wrong");

  // per-source gating: a status bit meeting its enable drops the pin
  // at the next edge; one check per source except time-stamp and trigger, so a miswired lane shows
  link_gate_a: assert property (
    (interrupt_status_reg[IEM_LINK_BIT] && enable_view[IEM_LINK_BIT])
      |=> !irq_b_r)
    else $error("enabled link-change status left the pin high");

  txdone_gate_a: assert property (
    (interrupt_status_reg[IEM_TXDONE_BIT] && enable_view[IEM_TXDONE_BIT])
      |=> !irq_b_r)
    else $error("enabled transmit-done status left the pin high");

  rxframe_gate_a: assert property (
    (interrupt_status_reg[IEM_RXFRAME_BIT] && enable_view[IEM_RXFRAME_BIT])
      |=> !irq_b_r)
    else $error("enabled frame-received status left the pin high");

  overrun_gate_a: assert property (
    (interrupt_status_reg[IEM_RXOVR_BIT] && enable_view[IEM_RXOVR_BIT])
      |=> !irq_b_r)
    else $error("enabled overrun status left the pin high");

  txstop_gate_a: assert property (
    (interrupt_status_reg[IEM_TXSTOP_BIT] && enable_view[IEM_TXSTOP_BIT])
      |=> !irq_b_r)
    else $error("enabled transmit-stopped status left the pin high");

  rxstop_gate_a: assert property (
    (interrupt_status_reg[IEM_RXSTOP_BIT] && enable_view[IEM_RXSTOP_BIT])
      |=> !irq_b_r)
    else $error("enabled receive-stopped status left the pin high");

  txspace_gate_a: assert property (
    (interrupt_status_reg[IEM_TXSPACE_BIT] && enable_view[IEM_TXSPACE_BIT])
      |=> !irq_b_r)
    else $error("enabled transmit-space status left the pin high");

  wframe_gate_a: assert property (
    (interrupt_status_reg[IEM_WFRAME_BIT] && enable_view[IEM_WFRAME_BIT])
      |=> !irq_b_r)
    else $error("enabled wake-frame status left the pin high");

  magic_gate_a: assert property (
    (interrupt_status_reg[IEM_MAGIC_BIT] && enable_view[IEM_MAGIC_BIT])
      |=> !irq_b_r)
    else $error("enabled magic-packet status left the pin high");

  linkup_gate_a: assert property (
    (interrupt_status_reg[IEM_LINKUP_BIT] && enable_view[IEM_LINKUP_BIT])
      |=> !irq_b_r)
    else $error("enabled link-up wake status left the pin high");

  energy_gate_a: assert property (
    (interrupt_status_reg[IEM_ENERGY_BIT] && enable_view[IEM_ENERGY_BIT])
      |=> !irq_b_r)
    else $error("enabled energy wake status left the pin high");

  // no live pair: the pin is released at the next edge
  no_pair_high_a: assert property (
    !(|(interrupt_status_reg & enable_view)) |=> irq_b_r)
    else $error("pin low with no enabled status bit");

  // wake-up status ignores write-one; only the clear code drops it,
  // so a driver that clears everything cannot lose a wake reason
  wake_w1c_a: assert property (
    (wr_status && pm_clear == 4'h0)
      |=> ((($past(interrupt_status_reg) & ~interrupt_status_reg)
        & IEM_PM_MASK) == 16'h0000))
    else $error("a status write dropped a wake-up status bit");

  // each one-hot clear code drops its own wake bit unless it re-arrives
  pm_frame_clr_a: assert property (
    (pm_clear == 4'h8 && !evt_wake_frame)
      |=> !interrupt_status_reg[IEM_WFRAME_BIT])
    else $error("clear code left the wake-frame status set");

  pm_magic_clr_a: assert property (
    (pm_clear == 4'h4 && !evt_magic_packet)
      |=> !interrupt_status_reg[IEM_MAGIC_BIT])
    else $error("clear code left the magic-packet status set");

  pm_linkup_clr_a: assert property (
    (pm_clear == 4'h2 && !evt_linkup_wake)
      |=> !interrupt_status_reg[IEM_LINKUP_BIT])
    else $error("clear code left the link-up wake status set");

  pm_energy_clr_a: assert property (
    (pm_clear == 4'h1 && !evt_energy_wake)
      |=> !interrupt_status_reg[IEM_ENERGY_BIT])
    else $error("clear code left the energy wake status set");

endmodule
`default_nettype wire

// ### tb/iem_host.sv
`timescale 1ns/1ps
`default_nettype none
// host processor model on the parallel register bus
module iem_host (
  input wire logic clk,
  output logic host_cs,
  output logic host_wr,
  output logic host_rd,
  output logic [11:0] host_addr,
  output logic [1:0] host_be,
  output logic [15:0] host_wdata,
  input wire logic [15:0] host_rdata_r
);
  import iem_pkg::*;
  // bus idle from time zero
  initial begin
    host_cs = 1'b0;
    host_wr = 1'b0;
    host_rd = 1'b0;
    host_addr = 12'h000;
    host_be = 2'b00;
    host_wdata = 16'h0000;
  end

  // release: stale address and data are inverted so they never match
  task automatic idle();
    host_cs = 1'b0;
    host_wr = 1'b0;
    host_rd = 1'b0;
    host_addr = ~host_addr;
    host_be = ~host_be;
    host_wdata = ~host_wdata;
  endtask

  // one write cycle, launched just after an edge, held over the taking edge
  task automatic wr(input logic [11:0] a, input logic [1:0] be,
                    input logic [15:0] d);
    @(posedge clk);
    #1;
    host_cs = 1'b1;
    host_wr = 1'b1;
    host_addr = a;
    host_be = be;
    // summary positions of the enable word always go out as zero
    host_wdata = (a == IEM_ENABLE_OFS) ? (d & 16'hEBFF) : d;
    @(posedge clk);
    #1;
    idle();
  endtask

  // one read cycle; data is taken a full cycle after the taking edge
  task automatic rd(input logic [11:0] a, output logic [15:0] d);
    @(posedge clk);
    #1;
    host_cs = 1'b1;
    host_rd = 1'b1;
    host_addr = a;
    @(posedge clk);
    #1;
    idle();
    @(posedge clk);
    #1;
    d = host_rdata_r;
  endtask
endmodule
`default_nettype wire

// ### tb/interrupt_enable_mask_tb.sv
`timescale 1ns/1ps
`default_nettype none
// self-checking bench for the interrupt enable block
module interrupt_enable_mask_tb;
  import iem_pkg::*;
  logic clk, rst_b, irq_b, cs, wr, rd;
  logic [11:0] addr;
  logic [1:0] be;
  logic [15:0] wdata, rdata, evt, d, m;
  logic [3:0] pm_clear;
  logic [11:0] ts_en, ts_st, tr_en, tr_st;
  int mismatches = 0;
  int tests_run = 0;
  int bits[13] = '{15, 14, 13, 12, 11, 10, 9, 8, 6, 5, 4, 3, 2};

  // 25 MHz system clock
  always #20 clk = ~clk;

  iem_host host (.clk(clk), .host_cs(cs), .host_wr(wr), .host_rd(rd),
    .host_addr(addr), .host_be(be), .host_wdata(wdata),
    .host_rdata_r(rdata));

  iem_top #(.UNITS(12)) DUT (.clk(clk), .rst_b(rst_b), .host_cs(cs),
    .host_wr(wr), .host_rd(rd), .host_addr(addr), .host_be(be),
    .host_wdata(wdata), .host_rdata_r(rdata),
    .evt_link_change(evt[15]), .evt_tx_done(evt[14]),
    .evt_rx_frame(evt[13]), .evt_timestamp(evt[12]),
    .evt_rx_overrun(evt[11]), .evt_trigger(evt[10]),
    .evt_tx_stopped(evt[9]), .evt_rx_stopped(evt[8]),
    .evt_tx_space(evt[6]), .evt_wake_frame(evt[5]),
    .evt_magic_packet(evt[4]), .evt_linkup_wake(evt[3]),
    .evt_energy_wake(evt[2]), .pm_clear(pm_clear),
    .timestamp_unit_enables(ts_en), .timestamp_unit_status(ts_st),
    .trigger_unit_enables(tr_en), .trigger_unit_status(tr_st),
    .irq_b_r(irq_b));

  // compare and count; four-state equality so unknowns never pass
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // step whole cycles, landing just after the edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic end_of_test();
    $display("compares %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // watchdog sized at about twelve times the expected run
  initial begin
    repeat (5000) @(posedge clk);
    mismatches++;
    $display("watchdog expired at %0t", $time);
    end_of_test();
  end

  initial begin
    clk = 1'b0;
    rst_b = 1'b0;
    evt = 16'h0000;
    pm_clear = 4'h0;
    {ts_en, ts_st, tr_en, tr_st} = 48'h0;
    tick(5);
    rst_b = 1'b1;
    // everything disabled and idle after reset
    host.rd(IEM_ENABLE_OFS, d);
    check(d, 16'h0000);
    host.rd(IEM_STATUS_OFS, d);
    check(d, 16'h0000);
    check({15'h0000, irq_b}, 16'h0001);
    $display("test reset done");
    // access kinds, byte lanes, reserved bits and an unmapped address
    host.wr(IEM_ENABLE_OFS, 2'b11, 16'hFFFF);
    host.rd(IEM_ENABLE_OFS, d);
    check(d, 16'hEBFC);
    check({15'h0000, irq_b}, 16'h0001);
    host.wr(IEM_ENABLE_OFS, 2'b01, 16'h0000);
    host.rd(IEM_ENABLE_OFS, d);
    check(d, 16'hEB00);
    host.wr(12'h194, 2'b11, 16'hFFFF);
    host.rd(12'h194, d);
    check(d, 16'h0000);
    host.wr(IEM_ENABLE_OFS, 2'b11, 16'h0000);
    $display("test access done");
    // each source: blocked while disabled, raised once enabled, cleared
    foreach (bits[i]) begin
      m = 16'h0001 << bits[i];
      evt = m;
      tick(1);
      evt = 16'h0000;
      tick(3);
      check({15'h0000, irq_b}, 16'h0001);
      ts_en = m[12] ? 12'h800 : 12'h000;
      ts_st = ts_en;
      tr_en = m[10] ? 12'h001 : 12'h000;
      tr_st = tr_en;
      host.wr(IEM_ENABLE_OFS, 2'b11, m);
      host.rd(IEM_ENABLE_OFS, d);
      check(d, m);
      check({15'h0000, irq_b}, 16'h0000);
      host.rd(IEM_STATUS_OFS, d);
      check(d, m);
      host.rd(IEM_STATUS_OFS, d);
      check(d, m);
      host.wr(IEM_STATUS_OFS, 2'b11, m);
      if ((m & 16'h003C) != 16'h0000) begin
        // wake sources ignore write-one and need the clear code
        host.rd(IEM_STATUS_OFS, d);
        check(d, m);
        pm_clear = m[5:2];
        tick(1);
        pm_clear = 4'h0;
      end
      tick(2);
      check({15'h0000, irq_b}, 16'h0001);
      host.rd(IEM_STATUS_OFS, d);
      check(d, 16'h0000);
      ts_st = 12'h000;
      tr_st = 12'h000;
      host.rd(IEM_ENABLE_OFS, d);
      check(d, m & 16'hEBFF);
      host.wr(IEM_ENABLE_OFS, 2'b11, 16'h0000);
      ts_en = 12'h000;
      tr_en = 12'h000;
      $display("test source bit %0d done", bits[i]);
    end
    // enabled sources: pin drops two edges after the event, and an
    // event landing on its own write-one clear survives
    host.wr(IEM_ENABLE_OFS, 2'b10, 16'hA000);
    evt = 16'h2000;
    tick(1);
    evt = 16'h0000;
    check({15'h0000, irq_b}, 16'h0001);
    tick(1);
    check({15'h0000, irq_b}, 16'h0000);
    fork
      host.wr(IEM_STATUS_OFS, 2'b10, 16'h8000);
      begin
        tick(1);
        evt = 16'h8000;
        tick(1);
        evt = 16'h0000;
      end
    join
    host.rd(IEM_STATUS_OFS, d);
    check(d, 16'hA000);
    check({15'h0000, irq_b}, 16'h0000);
    host.wr(IEM_STATUS_OFS, 2'b11, 16'hA000);
    tick(2);
    check({15'h0000, irq_b}, 16'h0001);
    $display("test enabled events done");
    // mid-run reset drops every enable and status bit
    host.wr(IEM_ENABLE_OFS, 2'b11, 16'hFFFF);
    evt = 16'h0800;
    tick(1);
    evt = 16'h0000;
    rst_b = 1'b0;
    tick(2);
    rst_b = 1'b1;
    host.rd(IEM_ENABLE_OFS, d);
    check(d, 16'h0000);
    host.rd(IEM_STATUS_OFS, d);
    check(d, 16'h0000);
    check({15'h0000, irq_b}, 16'h0001);
    $display("test mid-run reset done");
    end_of_test();
  end
endmodule
`default_nettype wire
